// ===== shared/dcu_pkg.sv
// Constants shared by the converter input shadow-update block.
package dcu_pkg;
	// Register indices on the plain register port.
	localparam logic [1:0] DCU_ADDR_HIGH = 2'h0;
	localparam logic [1:0] DCU_ADDR_LOW = 2'h1;
	localparam logic [1:0] DCU_ADDR_CTRL = 2'h2;
	localparam logic [1:0] DCU_ADDR_STAT = 2'h3;
	// Control register field positions.
	localparam int DCU_CTRL_ATE_BIT = 7;
	localparam int DCU_CTRL_TS_LSB = 4;
	localparam int DCU_CTRL_TS_W = 3;
	localparam int DCU_CTRL_LA_BIT = 2;
	localparam int DCU_CTRL_OE_BIT = 1;
	localparam int DCU_CTRL_EN_BIT = 0;
	localparam logic [7:0] DCU_CTRL_MASK = 8'hf7;
	// Status register field positions.
	localparam int DCU_STAT_PEND_BIT = 0;
	localparam int DCU_STAT_BUSY_BIT = 1;
	// Reset values.
	localparam logic [7:0] DCU_HIGH_RST = 8'h00;
	localparam logic [7:0] DCU_LOW_RST = 8'h00;
	localparam logic [7:0] DCU_CTRL_RST = 8'h00;
	localparam logic [9:0] DCU_VALUE_RST = 10'h000;
	// Data widths.
	localparam int DCU_VALUE_W = 10;
	localparam int DCU_TRIG_N = 8;
	// Conversion time and the derived cycle count, rounded up.
	localparam int DCU_CLK_PERIOD_NS = 10;
	localparam int DCU_CONV_TIME_NS = 1000;
	localparam int DCU_CONV_CYCLES =
		(DCU_CONV_TIME_NS + DCU_CLK_PERIOD_NS - 1) / DCU_CLK_PERIOD_NS;
	// Conversion state.
	typedef enum logic [1:0] {
		DCU_IDLE = 2'b01,
		DCU_BUSY = 2'b10
	} dcu_state_t;
endpackage

// ===== logic/dcu_rise_det.sv
// Rising-edge detector for a vector of same-clock flags.
`timescale 1ns/1ns
`default_nettype none
module dcu_rise_det #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] prev_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prev_q <= '0;
		end else begin
			prev_q <= level;
		end
	end

	assign rise = level & ~prev_q;
endmodule
`default_nettype wire

// ===== logic/dcu_dac_shadow.sv
// Converter input registers with shadow update, left adjust and auto-trigger.
//
// Overview of operation
// - Writing the low byte never changes the converter value until the high byte is written.
// - With left adjust clear, high byte bits 1:0 are value bits 9:8 and the low byte is 7:0.
// - With left adjust set, the high byte is bits 9:2 and low byte bits 7:6 are bits 1:0.
// - The converter is fed from a hidden shadow loaded from both bytes at once.
// - Without auto-trigger, each high-byte write loads the shadow at once.
// - With auto-trigger, the shadow loads on the selected trigger event, not on the write.
// - In auto-trigger mode a pending low-byte write blocks loading until the high byte follows.
// - In auto-trigger mode with only high-byte writes, every selected event while idle loads the shadow.
// - A change of left adjust is taken for the converter only at the next high-byte write.
// - A 3-bit select picks the trigger flag; its rising edge fires only while auto-trigger is enabled.
// - A further trigger edge during a conversion in progress is ignored.
`timescale 1ns/1ns
`default_nettype none
module dcu_dac_shadow
	import dcu_pkg::*;
#(
	parameter int CONV_CYC = DCU_CONV_CYCLES
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [DCU_TRIG_N-1:0] trig_flags,
	output logic [DCU_VALUE_W-1:0] dac_value,
	output logic dac_enable,
	output logic dac_out_enable,
	output logic dac_busy
);
	localparam int CW = $clog2(CONV_CYC + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);

	logic [7:0] high_q;
	logic [7:0] low_q;
	logic [7:0] ctrl_q;
	logic align_q;
	logic pend_q;
	logic [DCU_VALUE_W-1:0] shadow_q;
	logic [DCU_VALUE_W-1:0] shadow_d;
	logic [7:0] rdata_q;
	logic [CW-1:0] cnt_q;
	dcu_state_t state_q;

	function automatic logic [DCU_VALUE_W-1:0] pack_value(
		input logic [7:0] hi,
		input logic [7:0] lo,
		input logic left
	);
		logic [DCU_VALUE_W-1:0] v;
		v = left ? {hi, lo[7:6]} : {hi[1:0], lo};
		return v;
	endfunction

	wire wr_high = reg_wr && (reg_addr == DCU_ADDR_HIGH);
	wire wr_low = reg_wr && (reg_addr == DCU_ADDR_LOW);
	wire wr_ctrl = reg_wr && (reg_addr == DCU_ADDR_CTRL);
	wire auto_en = ctrl_q[DCU_CTRL_ATE_BIT];
	wire left_now = ctrl_q[DCU_CTRL_LA_BIT];
	wire [DCU_CTRL_TS_W-1:0] trig_sel =
		ctrl_q[DCU_CTRL_TS_LSB +: DCU_CTRL_TS_W];
	wire idle = (state_q == DCU_IDLE);

	wire [DCU_TRIG_N-1:0] flag_rise;

	dcu_rise_det #(
		.W(DCU_TRIG_N)
	) u_rise (
		.mclk(mclk),
		.nrst(nrst),
		.level(trig_flags),
		.rise(flag_rise)
	);

	wire sel_rise = flag_rise[trig_sel];
	wire trig_load = auto_en && sel_rise && !pend_q && idle;
	wire write_load = wr_high && !auto_en;
	wire load_any = trig_load || write_load;

	assign shadow_d = write_load ? pack_value(reg_wdata, low_q, left_now)
		: pack_value(high_q, low_q, align_q);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			high_q <= DCU_HIGH_RST;
			low_q <= DCU_LOW_RST;
			ctrl_q <= DCU_CTRL_RST;
		end else begin
			if (wr_high) begin
				high_q <= reg_wdata;
			end
			if (wr_low) begin
				low_q <= reg_wdata;
			end
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata & DCU_CTRL_MASK;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			align_q <= 1'b0;
		end else if (wr_high) begin
			align_q <= left_now;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pend_q <= 1'b0;
		end else if (wr_low) begin
			pend_q <= 1'b1;
		end else if (wr_high) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			shadow_q <= DCU_VALUE_RST;
		end else if (load_any) begin
			shadow_q <= shadow_d;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= DCU_IDLE;
			cnt_q <= '0;
		end else begin
			case (state_q)
				DCU_IDLE: begin
					if (load_any) begin
						state_q <= DCU_BUSY;
						cnt_q <= CONV_LAST;
					end
				end
				DCU_BUSY: begin
					if (write_load) begin
						cnt_q <= CONV_LAST;
					end else if (cnt_q == '0) begin
						state_q <= DCU_IDLE;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: begin
					state_q <= DCU_IDLE;
					cnt_q <= '0;
				end
			endcase
		end
	end

	wire [7:0] rd_high = left_now ? high_q : {6'h00, high_q[1:0]};
	wire [7:0] rd_low = left_now ? {low_q[7:6], 6'h00} : low_q;
	wire [7:0] rd_stat = {6'h00, !idle, pend_q};
	wire [7:0] rd_mux = (reg_addr == DCU_ADDR_HIGH) ? rd_high
		: (reg_addr == DCU_ADDR_LOW) ? rd_low
		: (reg_addr == DCU_ADDR_CTRL) ? ctrl_q
		: rd_stat;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 8'h00;
		end
	end

	assign reg_rdata = rdata_q;
	assign dac_value = shadow_q;
	assign dac_enable = ctrl_q[DCU_CTRL_EN_BIT];
	assign dac_out_enable = ctrl_q[DCU_CTRL_OE_BIT];
	assign dac_busy = !idle;

	default clocking dcu_cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence s_low_write;
		wr_low && !load_any;
	endsequence

	sequence s_manual_high;
		wr_high && !auto_en;
	endsequence

	sequence s_conv_start;
		load_any ##1 dac_busy;
	endsequence

	low_write_hold_a: assert property (
		s_low_write |=> $stable(dac_value))
		else $error("low byte write changed the converter value");

	right_pack_a: assert property (
		s_manual_high ##0 !left_now |=>
		dac_value == {$past(reg_wdata[1:0]), $past(low_q)})
		else $error("right adjusted value packed wrongly");

	left_pack_a: assert property (
		s_manual_high ##0 left_now |=>
		dac_value == {$past(reg_wdata), $past(low_q[7:6])})
		else $error("left adjusted value packed wrongly");

	shadow_only_load_a: assert property (
		!load_any |=> $stable(dac_value))
		else $error("shadow changed without a load");

	manual_busy_a: assert property (
		s_manual_high |=> dac_busy ##1 dac_busy)
		else $error("high write did not start a conversion");

	manual_quiet_a: assert property (
		!auto_en && !wr_high |=> $stable(dac_value))
		else $error("manual mode loaded without a high write");

	auto_write_hold_a: assert property (
		wr_high && auto_en && !trig_load |=> $stable(dac_value))
		else $error("auto mode loaded on a data write");

	auto_quiet_a: assert property (
		auto_en && !sel_rise |=> $stable(dac_value))
		else $error("auto mode loaded without a trigger edge");

	pend_block_a: assert property (
		auto_en && pend_q && !wr_high |=> $stable(dac_value))
		else $error("load happened with a low write pending");

	pend_set_a: assert property (
		wr_low |=> pend_q)
		else $error("low write did not mark a pending value");

	pend_clear_a: assert property (
		wr_high |=> !pend_q)
		else $error("high write did not clear the pending mark");

	trig_copy_a: assert property (
		auto_en && sel_rise && !pend_q && idle |=>
		dac_value == pack_value($past(high_q), $past(low_q), $past(align_q)))
		else $error("trigger did not load the data registers");

	align_defer_a: assert property (
		wr_ctrl && !load_any |=> $stable(dac_value) && (align_q == $past(align_q)))
		else $error("left adjust change acted before a high write");

	align_latch_a: assert property (
		wr_high |=> align_q == $past(left_now))
		else $error("alignment not taken at the high write");

	flag_edge_a: assert property (
		auto_en && idle && !pend_q && trig_flags[trig_sel]
		&& ((($past(trig_flags) >> trig_sel) & DCU_TRIG_N'(1)) == DCU_TRIG_N'(0))
		|=> dac_busy)
		else $error("selected flag edge did not fire an update");

	busy_ignore_a: assert property (
		s_conv_start ##0 (auto_en && sel_rise && !wr_high) |=> $stable(dac_value))
		else $error("trigger edge accepted during conversion");

	busy_drop_a: assert property (
		dac_busy && auto_en && sel_rise |=> $stable(dac_value))
		else $error("trigger edge loaded while busy");

	busy_end_a: assert property (
		dac_busy && cnt_q == '0 && !write_load |=> !dac_busy)
		else $error("busy window did not end");

	read_zero_a: assert property (
		reg_rd && reg_addr == DCU_ADDR_HIGH && !left_now |=> reg_rdata[7:2] == 6'h00)
		else $error("unused high byte bits read non zero");

	read_low_zero_a: assert property (
		reg_rd && reg_addr == DCU_ADDR_LOW && left_now |=> reg_rdata[5:0] == 6'h00)
		else $error("unused low byte bits read non zero");
endmodule
`default_nettype wire

// ===== dv/dcu_tb.sv
// Self-checking bench for the converter input shadow-update block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module testbench
	import dcu_pkg::*;
;
localparam int CC = 8;
logic mclk = 1'b0;
logic nrst = 1'b0;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
logic [1:0] reg_addr = 2'h0;
logic [7:0] reg_wdata = 8'h00;
logic [7:0] reg_rdata;
logic [7:0] rd_q;
logic [DCU_TRIG_N-1:0] trig_flags = 8'h00;
logic [DCU_VALUE_W-1:0] dac_value;
logic [DCU_VALUE_W-1:0] exp_v;
logic dac_enable;
logic dac_out_enable;
logic dac_busy;
int n_errors = 0;
int samples_checked = 0;
always #5 mclk = ~mclk;
dcu_dac_shadow #(.CONV_CYC(CC)) dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.trig_flags(trig_flags), .dac_value(dac_value), .dac_enable(dac_enable),
	.dac_out_enable(dac_out_enable), .dac_busy(dac_busy));
function automatic logic [9:0] pk(input logic [7:0] h, input logic [7:0] l, input logic la);
	return la ? {h, l[7:6]} : {h[1:0], l};
endfunction
task automatic tally_and_finish;
	$display("errors %0d checks %0d", n_errors, samples_checked);
	if (n_errors == 0 && samples_checked > 0) begin
		$display("[ PASS ]");
	end else begin
		$display("[ FAIL ]");
	end
	$finish;
endtask
task automatic wr(input logic [1:0] a, input logic [7:0] d);
	@(posedge mclk);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge mclk);
	reg_wr <= 1'b0;
	#1;
endtask
task automatic rd(input logic [1:0] a);
	@(posedge mclk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge mclk);
	reg_rd <= 1'b0;
	#1;
	rd_q = reg_rdata;
endtask
// A flag pulse high for one cycle gives one rising edge.
task automatic trig(input int s);
	@(posedge mclk);
	trig_flags[s] <= 1'b1;
	@(posedge mclk);
	trig_flags <= 8'h00;
	#1;
endtask
task automatic wait_idle;
	int i;
	for (i = 0; i < 40 && dac_busy !== 1'b0; i++) @(posedge mclk) #1;
	if (dac_busy !== 1'b0) begin
		n_errors++;
		$display("[FAIL] %0t busy never cleared", $time);
		tally_and_finish();
	end
endtask
// Counts the busy window in cycles; a window that never closes ends the run.
task automatic busy_len;
	int n;
	n = 0;
	while (dac_busy === 1'b1 && n < 40) begin
		@(posedge mclk);
		#1;
		n++;
	end
	`CHK(n, CC)
	if (n >= 40) begin
		tally_and_finish();
	end
endtask
task automatic t_reset;
	`CHK(dac_value, DCU_VALUE_RST)
	rd(DCU_ADDR_HIGH);
	`CHK(rd_q, DCU_HIGH_RST)
	rd(DCU_ADDR_LOW);
	`CHK(rd_q, DCU_LOW_RST)
endtask
task automatic t_manual;
	wr(DCU_ADDR_CTRL, 8'h03);
	`CHK({dac_enable, dac_out_enable}, 2'h3)
	wr(DCU_ADDR_LOW, 8'ha5);
	`CHK(dac_value, DCU_VALUE_RST)
	wr(DCU_ADDR_HIGH, 8'hfe);
	`CHK(dac_value, pk(8'hfe, 8'ha5, 1'b0))
	rd(DCU_ADDR_HIGH);
	`CHK(rd_q, 8'h02)
	rd(DCU_ADDR_LOW);
	`CHK(rd_q, 8'ha5)
endtask
task automatic t_left;
	wr(DCU_ADDR_CTRL, 8'h07);
	`CHK(dac_value, pk(8'hfe, 8'ha5, 1'b0))
	rd(DCU_ADDR_LOW);
	`CHK(rd_q, 8'h80)
	wr(DCU_ADDR_HIGH, 8'h5c);
	`CHK(dac_value, pk(8'h5c, 8'ha5, 1'b1))
	wr(DCU_ADDR_CTRL, 8'hff);
	rd(DCU_ADDR_CTRL);
	`CHK(rd_q, 8'hf7)
endtask
// Each source in turn, with left adjust alternating so both packings reach the shadow.
task automatic t_auto;
	int s;
	wait_idle();
	exp_v = dac_value;
	for (s = 0; s < 8; s++) begin
		wr(DCU_ADDR_CTRL, {1'b1, s[2:0], 1'b0, s[0], 2'h3});
		wr(DCU_ADDR_HIGH, 8'h10 + 8'(s));
		`CHK(dac_value, exp_v)
		trig((s + 1) % 8);
		`CHK(dac_value, exp_v)
		trig(s);
		exp_v = pk(8'h10 + 8'(s), 8'ha5, s[0]);
		`CHK(dac_value, exp_v)
		busy_len();
	end
endtask
task automatic t_pend;
	wr(DCU_ADDR_CTRL, 8'h87);
	wr(DCU_ADDR_LOW, 8'h40);
	rd(DCU_ADDR_STAT);
	`CHK(rd_q, 8'h01)
	trig(0);
	`CHK(dac_value, exp_v)
	wr(DCU_ADDR_HIGH, 8'h33);
	trig(0);
	`CHK(dac_value, pk(8'h33, 8'h40, 1'b1))
	`CHK(dac_busy, 1'b1)
	wr(DCU_ADDR_HIGH, 8'h44);
	trig(0);
	`CHK(dac_value, pk(8'h33, 8'h40, 1'b1))
	wait_idle();
	trig(0);
	`CHK(dac_value, pk(8'h44, 8'h40, 1'b1))
endtask
// Reset in the middle of a conversion must clear every register and the shadow.
task automatic t_mid_reset;
	@(posedge mclk);
	nrst <= 1'b0;
	repeat (3) @(posedge mclk);
	nrst <= 1'b1;
	#1;
	`CHK(dac_busy, 1'b0)
	rd(DCU_ADDR_CTRL);
	`CHK(rd_q, DCU_CTRL_RST)
	t_reset();
endtask
initial begin
	repeat (3) @(posedge mclk);
	nrst <= 1'b1;
	t_reset();
	t_manual();
	t_left();
	t_auto();
	t_pend();
	t_mid_reset();
	tally_and_finish();
end
endmodule
`default_nettype wire
